// >>> rtl/wbl_pkg.sv
// package: constants, types and state codes of the white balance tables
package wbl_pkg;

	// ********************************************************************
	// register map
	// ********************************************************************
	localparam logic [7:0] CTRL_OFFS   = 8'h2a;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam int         PAGE_MSB    = 7;
	localparam int         PAGE_LSB    = 6;
	localparam int         REMAP_BIT   = 5;
	localparam int         RELOAD_BIT  = 4;
	localparam logic [1:0] PAGE_CFG    = 2'h0;
	localparam logic [1:0] PAGE_RED    = 2'h1;
	localparam logic [1:0] PAGE_GREEN  = 2'h2;
	localparam logic [1:0] PAGE_BLUE   = 2'h3;

	// ********************************************************************
	// sizes and counts
	// ********************************************************************
	localparam int         NUM_COLORS  = 3;
	localparam int         TABLE_DEPTH = 256;
	localparam int         ENTRY_W     = 8;
	localparam int         FIFO_DEPTH  = 32;
	localparam logic [3:0] BITS_BYTE   = 4'h8;
	localparam logic [1:0] LOW2_ZERO   = 2'h0;
	localparam logic [7:0] DITH_MAX    = 8'hfc;

	// ********************************************************************
	// types
	// ********************************************************************
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} wbl_pix_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_RXB  = 7'h08,
		ST_RACK = 7'h10,
		ST_TXB  = 7'h20,
		ST_TACK = 7'h40
	} wbl_state_t;

endpackage : wbl_pkg

// >>> rtl/wbl_top.sv
// white balance lookup tables with serial control target and pixel fifo
`timescale 1ns/10ps
// Function
// - three tables, red green blue, each 256 entries of 8 bits
// - remapping on replaces each subpixel with its table entry
// - host can read and write every table entry
// - control bits 7:6 at 0x2a select config, red, green or blue page
// - control bit 5 turns remapping off or on
// - control bit 4 permits table rewrites after initial load
// - once remapping is first switched on, tables refuse writes unless reload permitted
// - reload while remapping runs does not disturb pixel stream
// - reload accepts any subset of entries in any table
// - six bit entries sit in upper bits with low bits 00
// - second dither stage reduces 8 bit table output to 6 bits
// - eight bit mode drives full 8 bit table output
// - tables are loaded over serial control bus, block is target
// - on table page addresses 0 to 255 map to entries

module wbl_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("fifo depth must be a power of two, at least 2");
	end

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule : wbl_fifo

module wbl_top #(
	parameter logic [6:0] TGT_ADDR = 7'h2c, // arbitrary
	parameter logic [6:0] CFG_ADDR = 7'h2d, // arbitrary
	parameter int         FIFO_D   = wbl_pkg::FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              second_dither_stage,
	input  wire logic              pix_in_valid,
	output logic                   pix_in_ready,
	input  wire wbl_pkg::wbl_pix_t pix_in,
	output logic                   pix_out_valid,
	input  wire logic              pix_out_ready,
	output wbl_pkg::wbl_pix_t      pix_out
);
	// ********************************************************************
	// declarations
	// ********************************************************************
	wbl_pkg::wbl_state_t st_reg;
	wbl_pkg::wbl_pix_t   fifo_out;
	wbl_pkg::wbl_pix_t   pix_next;
	logic       scl_q_reg;
	logic       sda_q_reg;
	logic       start_c;
	logic       stop_c;
	logic       rise;
	logic       fall;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic       rw_reg;
	logic       first_reg;
	logic       cfg_sel_reg;
	logic       nack_reg;
	logic [3:0] ctrl_reg;
	logic       locked_reg;
	logic [1:0] page;
	logic       remap_en;
	logic       reload_en;
	logic       wr_strobe;
	logic       ctrl_we;
	logic       tbl_we;
	logic [7:0] rd_data;
	logic [7:0] tbl_host [wbl_pkg::NUM_COLORS];
	logic [7:0] tbl_pix  [wbl_pkg::NUM_COLORS];
	logic [7:0] idx      [wbl_pkg::NUM_COLORS];
	logic       fifo_ov;
	logic       fifo_or;
	logic       adv;
	logic       out_valid_reg;
	logic [1:0] phase_reg;

	initial begin
		if (FIFO_D != wbl_pkg::FIFO_DEPTH)
			$error("pixel fifo depth must be 32");
	end

	// ********************************************************************
	// serial control target
	// ********************************************************************
	assign page      = ctrl_reg[wbl_pkg::PAGE_MSB-4:wbl_pkg::PAGE_LSB-4];
	assign remap_en  = ctrl_reg[wbl_pkg::REMAP_BIT-4];
	assign reload_en = ctrl_reg[wbl_pkg::RELOAD_BIT-4];
	assign start_c   = scl_in && scl_q_reg && sda_q_reg && !sda_in;
	assign stop_c    = scl_in && scl_q_reg && !sda_q_reg && sda_in;
	assign rise      = scl_in && !scl_q_reg;
	assign fall      = !scl_in && scl_q_reg;
	assign sda_out   = 1'b0;
	assign sda_oe    = (st_reg == wbl_pkg::ST_AACK) ||
		(st_reg == wbl_pkg::ST_RACK) ||
		((st_reg == wbl_pkg::ST_TXB) && !tx_reg[7]);
	assign wr_strobe = (st_reg == wbl_pkg::ST_RXB) && fall &&
		(cnt_reg == wbl_pkg::BITS_BYTE) && !first_reg;
	assign ctrl_we   = wr_strobe && (cfg_sel_reg || page ==
		wbl_pkg::PAGE_CFG) && (ptr_reg == wbl_pkg::CTRL_OFFS);
	assign tbl_we    = wr_strobe && !cfg_sel_reg &&
		(page != wbl_pkg::PAGE_CFG) &&
		(!locked_reg || reload_en);

	always_comb begin
		if (cfg_sel_reg || page == wbl_pkg::PAGE_CFG) begin
			if (ptr_reg == wbl_pkg::CTRL_OFFS)
				rd_data = {ctrl_reg, 4'h0};
			else
				rd_data = 8'h00;
		end else begin
			rd_data = tbl_host[page - 2'h1];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= scl_in;
			sda_q_reg <= sda_in;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg      <= wbl_pkg::ST_IDLE;
			cnt_reg     <= 4'h0;
			sh_reg      <= 8'h00;
			tx_reg      <= 8'hff;
			ptr_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			first_reg   <= 1'b0;
			cfg_sel_reg <= 1'b0;
			nack_reg    <= 1'b0;
		end else if (start_c) begin
			st_reg  <= wbl_pkg::ST_ADDR;
			cnt_reg <= 4'h0;
		end else if (stop_c) begin
			st_reg <= wbl_pkg::ST_IDLE;
		end else begin
			if (rise && (st_reg == wbl_pkg::ST_ADDR ||
				st_reg == wbl_pkg::ST_RXB || st_reg == wbl_pkg::ST_TXB)) begin
				sh_reg  <= {sh_reg[6:0], sda_in};
				cnt_reg <= cnt_reg + 4'h1;
			end
			case (st_reg)
			wbl_pkg::ST_ADDR: begin
				if (fall && cnt_reg == wbl_pkg::BITS_BYTE) begin
					cnt_reg     <= 4'h0;
					rw_reg      <= sh_reg[0];
					cfg_sel_reg <= (sh_reg[7:1] == CFG_ADDR);
					if (sh_reg[7:1] == TGT_ADDR || sh_reg[7:1] == CFG_ADDR)
						st_reg <= wbl_pkg::ST_AACK;
					else
						st_reg <= wbl_pkg::ST_IDLE;
				end
			end
			wbl_pkg::ST_AACK: begin
				if (fall) begin
					first_reg <= 1'b1;
					tx_reg    <= rd_data;
					st_reg    <= rw_reg ? wbl_pkg::ST_TXB : wbl_pkg::ST_RXB;
				end
			end
			wbl_pkg::ST_RXB: begin
				if (fall && cnt_reg == wbl_pkg::BITS_BYTE) begin
					cnt_reg   <= 4'h0;
					first_reg <= 1'b0;
					st_reg    <= wbl_pkg::ST_RACK;
					if (first_reg)
						ptr_reg <= sh_reg;
					else
						ptr_reg <= ptr_reg + 8'h01;
				end
			end
			wbl_pkg::ST_RACK: begin
				if (fall)
					st_reg <= wbl_pkg::ST_RXB;
			end
			wbl_pkg::ST_TXB: begin
				if (fall && cnt_reg == wbl_pkg::BITS_BYTE) begin
					cnt_reg <= 4'h0;
					tx_reg  <= 8'hff;
					ptr_reg <= ptr_reg + 8'h01;
					st_reg  <= wbl_pkg::ST_TACK;
				end else if (fall) begin
					tx_reg <= {tx_reg[6:0], 1'b1};
				end
			end
			wbl_pkg::ST_TACK: begin
				if (rise)
					nack_reg <= sda_in;
				if (fall) begin
					tx_reg <= rd_data;
					st_reg <= nack_reg ? wbl_pkg::ST_IDLE : wbl_pkg::ST_TXB;
				end
			end
			default: begin
				st_reg <= wbl_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// ********************************************************************
	// control register and load lock
	// ********************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg   <= wbl_pkg::CTRL_RESET[7:4];
			locked_reg <= 1'b0;
		end else if (ctrl_we) begin
			ctrl_reg <= sh_reg[7:4];
			if (sh_reg[wbl_pkg::REMAP_BIT])
				locked_reg <= 1'b1;
		end
	end

	// ********************************************************************
	// colour tables
	// ********************************************************************
	assign idx[0] = fifo_out.r;
	assign idx[1] = fifo_out.g;
	assign idx[2] = fifo_out.b;

	for (genvar c = 0; c < wbl_pkg::NUM_COLORS; c++) begin : gen_tbl
		logic [wbl_pkg::ENTRY_W-1:0] mem [wbl_pkg::TABLE_DEPTH];
		always_ff @(posedge clk) begin
			if (tbl_we && page == 2'(c + 1))
				mem[ptr_reg] <= sh_reg;
		end
		assign tbl_host[c] = mem[ptr_reg];
		assign tbl_pix[c]  = mem[idx[c]];
	end

	// ********************************************************************
	// pixel path
	// ********************************************************************
	function automatic logic [7:0] dith6(input logic [7:0] v,
		input logic [1:0] ph);
		logic [8:0] s;
		s = {1'b0, v} + {7'h00, ph};
		dith6 = s[8] ? wbl_pkg::DITH_MAX : {s[7:2], wbl_pkg::LOW2_ZERO};
	endfunction : dith6

	wbl_fifo #(
		.W     ($bits(wbl_pkg::wbl_pix_t)),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.in_data   (pix_in),
		.out_valid (fifo_ov),
		.out_ready (fifo_or),
		.out_data  (fifo_out)
	);

	assign fifo_or       = !out_valid_reg || pix_out_ready;
	assign adv           = fifo_ov && fifo_or;
	assign pix_out_valid = out_valid_reg;

	always_comb begin
		if (remap_en)
			pix_next = '{r: tbl_pix[0], g: tbl_pix[1], b: tbl_pix[2]};
		else
			pix_next = fifo_out;
		if (second_dither_stage) begin
			pix_next.r = dith6(pix_next.r, phase_reg);
			pix_next.g = dith6(pix_next.g, phase_reg);
			pix_next.b = dith6(pix_next.b, phase_reg);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_valid_reg <= 1'b0;
			pix_out       <= '0;
			phase_reg     <= 2'h0;
		end else if (fifo_or) begin
			out_valid_reg <= fifo_ov;
			if (adv) begin
				pix_out   <= pix_next;
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end

	// ********************************************************************
	// assertions
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_remap;
		adv && remap_en && !second_dither_stage |=>
			pix_out.r == $past(tbl_pix[0]) && pix_out.b == $past(tbl_pix[2]);
	endproperty
	a_remap: assert property (p_remap) else $error("remap mismatch");

	property p_bypass;
		adv && !remap_en && !second_dither_stage |=>
			pix_out == $past(fifo_out) && pix_out_valid;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass changed");

	property p_ctrl;
		ctrl_we |=> remap_en == $past(sh_reg[wbl_pkg::REMAP_BIT]) &&
			reload_en == $past(sh_reg[wbl_pkg::RELOAD_BIT]);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control bits wrong");

	property p_lock;
		wr_strobe && locked_reg && !reload_en |-> !tbl_we;
	endproperty
	a_lock: assert property (p_lock) else $error("write while locked");

	property p_tblwr;
		tbl_we && page == wbl_pkg::PAGE_RED |=>
			gen_tbl[0].mem[$past(ptr_reg)] == $past(sh_reg);
	endproperty
	a_tblwr: assert property (p_tblwr) else $error("entry not stored");

	property p_ctrl_rd;
		cfg_sel_reg && ptr_reg == wbl_pkg::CTRL_OFFS |->
			rd_data == {ctrl_reg, 4'h0};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read bad");

	property p_dither;
		adv && second_dither_stage |=>
			pix_out.r[1:0] == 2'h0 && pix_out.g[1:0] == 2'h0;
	endproperty
	a_dither: assert property (p_dither) else $error("low bits set");

	property p_hold;
		pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output dropped");

	property p_sda;
		sda_oe |-> st_reg != wbl_pkg::ST_IDLE && st_reg != wbl_pkg::ST_ADDR;
	endproperty
	a_sda: assert property (p_sda) else $error("drove bus idle");

	c_remap:  cover property (adv && remap_en);
	c_reload: cover property (tbl_we && locked_reg && remap_en);
	c_full:   cover property (!pix_in_ready);
	c_dith:   cover property (adv && second_dither_stage);

endmodule : wbl_top

// >>> test/wbl_host.sv
// host controller model of the serial control bus
`timescale 1ns/10ps
module wbl_host (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk
	// scl low 4 clocks with sda moving midway, then high 3
	task automatic bit_io(input logic b, output logic r);
		scl = 1'b0;
		tk(2);
		sda_oe = ~b;
		tk(2);
		scl = 1'b1;
		tk(3);
		r = sda;
	endtask : bit_io
	// start when st is 1, stop when 0: sda moves while scl high
	task automatic cond(input logic st);
		scl = 1'b0;
		tk(2);
		sda_oe = ~st;
		tk(2);
		scl = 1'b1;
		tk(3);
		sda_oe = st;
		tk(3);
	endtask : cond
	task automatic xfer(input logic [7:0] d, input logic nk,
			output logic [7:0] q, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nk, r);
		ak = ~r;
	endtask : xfer
	task automatic wr(input logic [6:0] a, input logic [7:0] o,
			input logic [7:0] d[$], output logic ok);
		logic [7:0] q;
		logic       k;
		cond(1'b1);
		xfer({a, 1'b0}, 1'b1, q, ok);
		xfer(o, 1'b1, q, k);
		ok &= k;
		foreach (d[i]) begin
			xfer(d[i], 1'b1, q, k);
			ok &= k;
		end
		cond(1'b0);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] o,
			output logic [7:0] v);
		logic k;
		cond(1'b1);
		xfer({a, 1'b0}, 1'b1, v, k);
		xfer(o, 1'b1, v, k);
		cond(1'b1);
		xfer({a, 1'b1}, 1'b1, v, k);
		xfer(8'hff, 1'b1, v, k);
		cond(1'b0);
	endtask : rd
endmodule : wbl_host

// >>> test/wbl_top_test.sv
// self-checking bench of the white balance tables
`timescale 1ns/10ps
module wbl_top_test;
	localparam logic [6:0] TGT = 7'h2c;
	localparam logic [6:0] CFG = 7'h2d;
	localparam logic [7:0] CA  = wbl_pkg::CTRL_OFFS;
	logic              clk   = 1'b0;
	logic              nrst  = 1'b0;
	logic              scl;
	logic              h_oe;
	logic              d_oe;
	logic              sdo;
	logic              sda;
	logic              dith  = 1'b0;
	logic              iv    = 1'b0;
	logic              ir;
	logic              ov;
	logic              ordy  = 1'b1;
	logic              hold  = 1'b0;
	logic              avd   = 1'b0;
	logic              remap = 1'b0;
	wbl_pkg::wbl_pix_t pi    = '0;
	wbl_pkg::wbl_pix_t po;
	wbl_pkg::wbl_pix_t exq[$];
	logic [7:0]        lut[3][256];
	logic [7:0]        bq[$];
	logic [7:0]        v;
	logic [7:0]        ix;
	logic              ack;
	int                acc;
	int                cyc   = 0;
	int                n_mismatch = 0;
	int                n_compared = 0;

	// pull-up on the shared data line
	assign sda = ~(h_oe | d_oe);
	always #4 clk = ~clk;

	wbl_host host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
	wbl_top #(.TGT_ADDR(TGT), .CFG_ADDR(CFG), .FIFO_D(32)) DUT (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sdo), .sda_oe(d_oe), .second_dither_stage(dith),
		.pix_in_valid(iv), .pix_in_ready(ir), .pix_in(pi),
		.pix_out_valid(ov), .pix_out_ready(ordy), .pix_out(po));

	// ********
	// checking
	// ********
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task automatic tally(input logic ok, input logic [23:0] g,
			input logic [23:0] e);
		n_compared++;
		if (!ok) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : tally
	task automatic chk_bit(input logic g, input logic e);
		tally(g === e, {23'h0, g}, {23'h0, e});
	endtask : chk_bit
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		tally(g === e, {16'h0, g}, {16'h0, e});
	endtask : chk_reg
	task automatic chk_pix(input wbl_pkg::wbl_pix_t g,
			input wbl_pkg::wbl_pix_t e);
		tally(g === e, g, e);
	endtask : chk_pix
	function automatic logic dok(input logic [7:0] g, input logic [7:0] e);
		logic [7:0] lo;
		lo = e & 8'hfc;
		return g === lo || g === (lo == 8'hfc ? lo : lo + 8'h04);
	endfunction : dok
	function automatic wbl_pkg::wbl_pix_t exp_pix(input wbl_pkg::wbl_pix_t p);
		wbl_pkg::wbl_pix_t q;
		q = p;
		if (remap) begin
			q.r = lut[0][p.r];
			q.g = lut[1][p.g];
			q.b = lut[2][p.b];
		end
		return q;
	endfunction : exp_pix

	always @(posedge clk) begin
		#1;
		ordy = hold ? 1'b0 : ($urandom_range(3) != 0);
	end
	always @(posedge clk) begin : mon
		wbl_pkg::wbl_pix_t e;
		if (nrst && ov && ordy) begin
			if (exq.size() == 0) begin
				chk_bit(1'b0, 1'b1);
			end else begin
				e = exq.pop_front();
				if (dith)
					chk_bit(dok(po.r, e.r) & dok(po.g, e.g) & dok(po.b, e.b), 1'b1);
				else
					chk_pix(po, e);
			end
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			results();
		end
	end

	// *******
	// drivers
	// *******
	task automatic push(input int n);
		logic t;
		for (int k = 0; k < n; k++) begin
			pi = 24'($urandom);
			if (avd)
				pi.g[7] = 1'b1;
			iv = hold | ($urandom_range(3) != 0);
			#6 t = iv & ir;
			@(posedge clk) #1;
			if (t) begin
				exq.push_back(exp_pix(pi));
				acc++;
			end
		end
		iv = 1'b0;
	endtask : push
	task automatic drain;
		for (int k = 0; k < 300; k++) begin
			if (exq.size() == 0)
				break;
			@(posedge clk) #1;
		end
		chk_bit(exq.size() == 0, 1'b1);
	endtask : drain
	task automatic wreg(input logic [6:0] a, input logic [7:0] o);
		host.wr(a, o, bq, ack);
		chk_bit(ack, 1'b1);
	endtask : wreg
	task automatic rcmp(input logic [6:0] a, input logic [7:0] o,
			input logic [7:0] e);
		host.rd(a, o, v);
		chk_reg(v, e);
	endtask : rcmp
	task automatic ctl(input logic [1:0] pg, input logic rm, input logic rl);
		bq = {{pg, rm, rl, 4'h0}};
		wreg(CFG, CA);
		remap = rm;
		rcmp(CFG, CA, {pg, rm, rl, 4'h0});
	endtask : ctl

	initial begin
		void'($urandom(32'hf50e));
		repeat (8) @(posedge clk);
		#1 nrst = 1'b1;
		chk_bit(ir, 1'b1);
		chk_bit(ov, 1'b0);
		chk_bit(sdo, 1'b0);
		rcmp(CFG, CA, wbl_pkg::CTRL_RESET);
		push(30);
		drain();
		for (int c = 0; c < 3; c++) begin
			ctl(2'(c + 1), 1'b0, 1'b0);
			bq = {};
			for (int i = 0; i < 256; i++) begin
				lut[c][i] = c == 1 ? {6'($urandom), 2'b00} : 8'($urandom);
				bq.push_back(lut[c][i]);
			end
			wreg(TGT, 8'h00);
			ix = 8'($urandom);
			rcmp(TGT, 8'h00, lut[c][0]);
			rcmp(TGT, 8'hff, lut[c][255]);
			rcmp(TGT, ix, lut[c][ix]);
		end
		ctl(2'h0, 1'b1, 1'b0);
		push(200);
		drain();
		ctl(2'h1, 1'b1, 1'b0);
		bq = {~lut[0][7]};
		wreg(TGT, 8'h07);
		rcmp(TGT, 8'h07, lut[0][7]);
		ctl(2'h2, 1'b1, 1'b1);
		avd = 1'b1;
		fork
			push(500);
			begin
				bq = {};
				for (int i = 0; i < 4; i++) begin
					lut[1][8'h20 + i] = {6'($urandom), 2'b00};
					bq.push_back(lut[1][8'h20 + i]);
				end
				wreg(TGT, 8'h20);
			end
		join
		avd = 1'b0;
		drain();
		rcmp(TGT, 8'h22, lut[1][8'h22]);
		push(200);
		drain();
		dith = 1'b1;
		push(60);
		drain();
		dith = 1'b0;
		hold = 1'b1;
		acc = 0;
		push(40);
		chk_bit(acc >= 32 && acc <= 33, 1'b1);
		chk_bit(ir, 1'b0);
		hold = 1'b0;
		drain();
		results();
	end
endmodule : wbl_top_test
